// ### frtic_defs.svh
// register map, field layout, reset values and codes of the timer block
//
// Behaviour
// RULE1 - prescaler divides clock by 1, 4, 8, 16
// RULE2 - 16-bit counter counts up from zero after reset
// RULE3 - at all-ones wrap, set overflow, keep counting
// RULE4 - software cannot reset, load or stop counter
// RULE5 - watchdog tap is clock divided by 2^15
// RULE6 - three captures, four compares, one shared channel
// RULE7 - selected edge latches count into capture register
// RULE8 - edges synchronised; latch uses stable count value
// RULE9 - port read returns live level of pins
// RULE10 - select bit picks shared capture, reset compare
// RULE11 - software pin writes trigger shared captures
// RULE12 - shared register ignores writes while capturing
// RULE13 - edge field: off, rising, falling, both
// RULE14 - reset disables every capture channel
// RULE15 - same-cycle edges capture identical count
// RULE16 - compare-owned pins ignore software port writes
// RULE17 - first compare drives chosen upper pins
// RULE18 - every timer event has own enable, request
// RULE19 - reset makes shared pin an input; code drives it from compare after reset, since ccs resets to compare
// RULE20 - capture register read delays capture one cycle
// RULE21 - reset leaves capture registers untouched
// RULE22 - capture sets channel flag, enabled flag requests
`ifndef FRTIC_DEFS_SVH
`define FRTIC_DEFS_SVH
// word indexes; byte address is four times the index
`define FRTIC_IDX_COUNT 6'h00
`define FRTIC_IDX_CTRL 6'h01
`define FRTIC_IDX_EDGE 6'h02
`define FRTIC_IDX_MASK 6'h03
`define FRTIC_IDX_FLAGS 6'h04
`define FRTIC_IDX_PORT 6'h05
`define FRTIC_IDX_OC1 6'h06
`define FRTIC_IDX_CAP1 6'h08
`define FRTIC_IDX_SHARED 6'h0B
`define FRTIC_IDX_CMP1 6'h0C
// control field positions
`define FRTIC_CTRL_CCS 2
`define FRTIC_CTRL_DIR 3
// prescaler divider masks
`define FRTIC_PRE_MASK_1 4'h0
`define FRTIC_PRE_MASK_4 4'h3
`define FRTIC_PRE_MASK_8 4'h7
`define FRTIC_PRE_MASK_16 4'hF
// flag positions
`define FRTIC_FLAG_CMP5 8
`define FRTIC_FLAG_OVF 9
// reset and limit values
`define FRTIC_COUNT_MAX 16'hFFFF
`define FRTIC_SHARED_RESET 16'hFFFF
`define FRTIC_CMP_RESET 16'hFFFF
`define FRTIC_WD_TAP 15'h7FFF
`endif

// ### frtic_pkg.sv
// types shared by the timer block
`default_nettype none
package frtic_pkg;
  typedef logic [15:0] frtic_count_type;
  typedef logic [5:0] frtic_index_type;
endpackage
`default_nettype wire

// ### frtic_timer.sv
// free-running timer with capture and compare channels, Avalon-MM slave
`default_nettype none
`include "frtic_defs.svh"
module frtic_timer
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_b,
  output logic [9:0] irq_req,
  output logic watchdog_tick
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0] pre_div, pre_mask;
  logic tick, ccs, dir, match5, ovf, wr_go, rd_go;
  frtic_pkg::frtic_count_type count, shared_reg;
  logic [14:0] wd_div;
  logic [1:0] prescale;
  logic [7:0] edge_ctl, port_data, pin_s1, pin_s2;
  logic [9:0] mask, flags, set_ev, clr_ev;
  logic [4:0] oc1_mask, oc1_data;
  frtic_pkg::frtic_count_type cap [0:2];
  frtic_pkg::frtic_count_type cmp [0:3], pend_val [0:3], xfer_val [0:3];
  logic [3:0] cap_src, cap_prev, cap_en, cap_edge, pending, blk, xfer, match;
  logic [7:3] cmp_lvl;
  frtic_pkg::frtic_index_type widx;
  logic [31:0] rd_val, be_mask, wm;

  // ----------------------------------------------------------------
  // prescaler, counter, watchdog tap
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (prescale)
      2'h0: pre_mask = `FRTIC_PRE_MASK_1; // [RULE1]
      2'h1: pre_mask = `FRTIC_PRE_MASK_4;
      2'h2: pre_mask = `FRTIC_PRE_MASK_8;
      2'h3: pre_mask = `FRTIC_PRE_MASK_16;
    endcase
  end

  assign tick = (pre_div & pre_mask) == pre_mask; // [RULE1]
  assign ovf = tick && (count == `FRTIC_COUNT_MAX);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      pre_div <= 4'h0;
    else
      pre_div <= pre_div + 4'h1;
  end

  // no bus path reaches the counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      count <= 16'h0000; // [RULE2] [RULE4]
    else if (tick)
      count <= count + 16'h0001; // [RULE3]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wd_div <= 15'h0000;
      watchdog_tick <= 1'b0;
    end
    else
    begin
      wd_div <= wd_div + 15'h0001;
      watchdog_tick <= wd_div == `FRTIC_WD_TAP; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign widx = avs_address[7:2];
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && !avs_waitrequest;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wm = (rd_val & ~be_mask) | (avs_writedata & be_mask);
  assign clr_ev = (wr_go && widx == `FRTIC_IDX_FLAGS) ? wm[9:0] : 10'h000;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (widx)
      `FRTIC_IDX_COUNT: rd_val[15:0] = count;
      `FRTIC_IDX_CTRL: rd_val[3:0] = {dir, ccs, prescale};
      `FRTIC_IDX_EDGE: rd_val[7:0] = edge_ctl;
      `FRTIC_IDX_MASK: rd_val[9:0] = mask;
      `FRTIC_IDX_FLAGS: rd_val[9:0] = flags;
      `FRTIC_IDX_PORT: rd_val[7:0] = pin_s2; // [RULE9]
      `FRTIC_IDX_OC1: rd_val[12:0] = {oc1_data, 3'h0, oc1_mask};
      6'h08: rd_val[15:0] = cap[0];
      6'h09: rd_val[15:0] = cap[1];
      6'h0A: rd_val[15:0] = cap[2];
      `FRTIC_IDX_SHARED: rd_val[15:0] = shared_reg;
      6'h0C: rd_val[15:0] = cmp[0];
      6'h0D: rd_val[15:0] = cmp[1];
      6'h0E: rd_val[15:0] = cmp[2];
      6'h0F: rd_val[15:0] = cmp[3];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // one wait cycle, then answer
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_val : 32'h0000_0000;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      prescale <= 2'h0;
      ccs <= 1'b0; // [RULE10]
      dir <= 1'b0; // [RULE19]
      edge_ctl <= 8'h00; // [RULE14]
      mask <= 10'h000;
      port_data <= 8'h00;
      oc1_mask <= 5'h00;
      oc1_data <= 5'h00;
    end
    else if (wr_go)
    begin
      if (widx == `FRTIC_IDX_CTRL)
      begin
        prescale <= wm[1:0];
        ccs <= wm[`FRTIC_CTRL_CCS];
        dir <= wm[`FRTIC_CTRL_DIR];
      end
      if (widx == `FRTIC_IDX_EDGE)
        edge_ctl <= wm[7:0]; // [RULE13]
      if (widx == `FRTIC_IDX_MASK)
        mask <= wm[9:0]; // [RULE18]
      if (widx == `FRTIC_IDX_PORT)
        port_data <= wm[7:0];
      if (widx == `FRTIC_IDX_OC1)
      begin
        oc1_mask <= wm[4:0];
        oc1_data <= wm[12:8];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (!rst_b)
        cmp[i] <= `FRTIC_CMP_RESET;
      else if (wr_go && widx == `FRTIC_IDX_CMP1 + 6'(i))
        cmp[i] <= wm[15:0];
  end

  // ----------------------------------------------------------------
  // capture front end
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end
    else
    begin
      pin_s1 <= port_a_in; // [RULE8]
      pin_s2 <= pin_s1;
    end
  end

  // driven shared pin feeds its own capture
  assign cap_src = {dir ? port_data[3] : pin_s2[3], pin_s2[2:0]}; // [RULE11]
  assign cap_en = {ccs, 3'h7}; // [RULE10]

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      cap_edge[i] = cap_en[i]
        && ((edge_ctl[2 * i] && cap_src[i] && !cap_prev[i])
        || (edge_ctl[2 * i + 1] && !cap_src[i] && cap_prev[i])); // [RULE13]
      blk[i] = rd_go && widx == `FRTIC_IDX_CAP1 + 6'(i); // [RULE20]
      xfer[i] = (cap_edge[i] || pending[i]) && !blk[i];
      // count sampled before this edge's increment
      xfer_val[i] = cap_edge[i] ? count : pend_val[i]; // [RULE8] [RULE15]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cap_prev <= 4'h0;
      pending <= 4'h0;
    end
    else
    begin
      cap_prev <= cap_src;
      pending <= (cap_edge | pending) & blk; // [RULE20]
    end
  end

  // no reset on captured values
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (cap_edge[i])
        pend_val[i] <= count;
    for (int i = 0; i < 3; i++)
      if (xfer[i])
        cap[i] <= xfer_val[i]; // [RULE7] [RULE21]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      shared_reg <= `FRTIC_SHARED_RESET;
    else if (xfer[3])
      shared_reg <= xfer_val[3]; // [RULE7]
    else if (wr_go && widx == `FRTIC_IDX_SHARED && !ccs)
      shared_reg <= wm[15:0]; // [RULE12]
  end

  // ----------------------------------------------------------------
  // compare channels and pins
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      match[i] = tick && count == cmp[i]; // [RULE6]
  end

  assign match5 = tick && !ccs && count == shared_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cmp_lvl <= 5'h00;
    else
    begin
      for (int i = 0; i < 5; i++)
        if (match[0] && oc1_mask[i])
          cmp_lvl[i + 3] <= oc1_data[i]; // [RULE17]
        else if (i == 0 && match5)
          cmp_lvl[3] <= !cmp_lvl[3];
        else if (i > 0 && i < 4 && match[(4 - i) % 4])
          cmp_lvl[i + 3] <= !cmp_lvl[i + 3];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      port_a_out <= 8'h00;
      port_a_oe_b <= 8'hFF;
    end
    else
    begin
      port_a_out <= {cmp_lvl[7:4], ccs ? port_data[3] : cmp_lvl[3], 3'h0}; // [RULE16]
      port_a_oe_b <= {!oc1_mask[4], 3'h0, ccs && !dir, 3'h7};
    end
  end

  // ----------------------------------------------------------------
  // flags and requests
  // ----------------------------------------------------------------
  assign set_ev = {ovf, match5, match, xfer}; // [RULE22]

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      flags <= 10'h000;
      irq_req <= 10'h000;
    end
    else
    begin
      flags <= (flags & ~clr_ev) | set_ev; // [RULE3] [RULE22]
      irq_req <= flags & mask; // [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_wrap;
    ovf |=> count == 16'h0000 && flags[`FRTIC_FLAG_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap failed"); // [RULE3]

  property p_step;
    rst_b && tick |=> count == $past(count) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count step wrong"); // [RULE2]
  property p_div16;
    prescale == 2'h3 && tick && $stable(prescale) |=> (!tick || prescale != 2'h3) [*8];
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 broken"); // [RULE1]

  property p_capture;
    xfer[0] && cap_edge[0] |=> cap[0] == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // [RULE7]

  property p_block;
    cap_edge[1] && blk[1] |=> pending[1] ##1 cap[1] == $past(pend_val[1], 1);
  endproperty
  a_block: assert property (p_block) else $error("blocked capture lost"); // [RULE20]

  property p_shared_wr;
    ccs && wr_go && widx == `FRTIC_IDX_SHARED && !xfer[3] |=> $stable(shared_reg);
  endproperty
  a_shared_wr: assert property (p_shared_wr) else $error("shared written"); // [RULE12]

  property p_set_wins;
    set_ev[0] && clr_ev[0] |=> flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost"); // [RULE22]

  property p_watchdog;
    wd_div == `FRTIC_WD_TAP |=> watchdog_tick ##1 !watchdog_tick;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("tap missing"); // [RULE5]
  property p_compare_pin;
    rst_b && !ccs |=> !port_a_oe_b[3];
  endproperty
  a_compare_pin: assert property (p_compare_pin) else $error("pin3 not driven"); // [RULE16]

  property p_disabled;
    edge_ctl[1:0] == 2'h0 && !pending[0] && !flags[0] |=> !flags[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled captured"); // [RULE13]

endmodule
`default_nettype wire

// ### frtic_pin_model.sv
// pin-level model of the signals outside the timer port
`default_nettype none
module frtic_pin_model
(
  input wire logic [7:0] ext_level,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_b,
  output logic [7:0] port_a_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pin the timer drives reads back its own level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      port_a_in[i] = port_a_oe_b[i] ? ext_level[i] : port_a_out[i];
    end
  end
endmodule
`default_nettype wire

// ### tb_frtic_timer.sv
// self-checking testbench of the timer block
`default_nettype none
`include "frtic_defs.svh"
module tb_frtic_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] port_a_in;
  logic [7:0] port_a_out;
  logic [7:0] port_a_oe_b;
  logic [9:0] irq_req;
  logic watchdog_tick;
  logic [7:0] ext_level;
  logic [31:0] q;
  logic [31:0] c0;
  logic [31:0] c1;
  int n_errors;
  int tests_run;
  int ticks;
  frtic_timer dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_a_in(port_a_in), .port_a_out(port_a_out),
    .port_a_oe_b(port_a_oe_b), .irq_req(irq_req), .watchdog_tick(watchdog_tick));
  frtic_pin_model pins (.ext_level(ext_level), .port_a_out(port_a_out),
    .port_a_oe_b(port_a_oe_b), .port_a_in(port_a_in));
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access; wr high writes d, low reads into q
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
      check(32'h0BAD, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // idle edge so a next call never reassigns in this step
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [5:0] idx);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ext_level = 8'h00;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(`FRTIC_IDX_COUNT);
    check({16'h0, q[15:4]}, 32'h0);
    rd(`FRTIC_IDX_CTRL);
    check(q, 32'h0);
    rd(`FRTIC_IDX_EDGE);
    check(q, 32'h0);
    rd(`FRTIC_IDX_SHARED);
    check(q, 32'h0000FFFF);
    check({31'h0, port_a_oe_b[3]}, 32'h0);
    rd(6'h3F);
    check(q, 32'h0);
    // count advance over 16 cycles for every prescale code
    for (int p = 0; p < 4; p++)
    begin
      wr(`FRTIC_IDX_CTRL, p);
      rd(`FRTIC_IDX_COUNT);
      c0 = q;
      repeat (13) @(posedge core_clk);
      rd(`FRTIC_IDX_COUNT);
      check((q - c0) & 32'hFFFF, 32'd16 >> (p == 0 ? 0 : p + 1));
    end
    // a write to the counter must not disturb it
    wr(`FRTIC_IDX_CTRL, 32'h0);
    rd(`FRTIC_IDX_COUNT);
    c0 = q;
    wr(`FRTIC_IDX_COUNT, 32'h0);
    repeat (10) @(posedge core_clk);
    rd(`FRTIC_IDX_COUNT);
    check((q - c0) & 32'hFFFF, 32'd16);
    // one full count period: one wrap, two watchdog pulses
    wr(`FRTIC_IDX_FLAGS, 32'h3FF);
    ticks = 0;
    repeat (65536)
    begin
      @(posedge core_clk);
      if (watchdog_tick === 1'b1)
        ticks++;
    end
    check(ticks, 32'd2);
    rd(`FRTIC_IDX_FLAGS);
    check(q[9], 1'b1);
    wr(`FRTIC_IDX_MASK, 32'h201);
    repeat (3) @(posedge core_clk);
    check(irq_req[9], 1'b1);
    // captures on pins 0-2: rising, falling, both
    wr(`FRTIC_IDX_EDGE, 32'h39);
    wr(`FRTIC_IDX_FLAGS, 32'h3FF);
    ext_level <= 8'h07;
    repeat (8) @(posedge core_clk);
    rd(`FRTIC_IDX_FLAGS);
    check(q[3:0], 4'b0101);
    check(irq_req[1:0], 2'b01);
    rd(`FRTIC_IDX_PORT);
    check(q[2:0], 3'b111);
    rd(`FRTIC_IDX_CAP1);
    c0 = q;
    rd(`FRTIC_IDX_CAP1 + 6'h2);
    c1 = q;
    check(c1, c0);
    wr(`FRTIC_IDX_FLAGS, 32'h3FF);
    ext_level <= 8'h00;
    // capture 2 read accepted on its own capture edge
    @(posedge core_clk);
    rd(`FRTIC_IDX_CAP1 + 6'h1);
    repeat (8) @(posedge core_clk);
    rd(`FRTIC_IDX_FLAGS);
    check(q[3:0], 4'b0110);
    rd(`FRTIC_IDX_CAP1);
    check(q, c0);
    rd(`FRTIC_IDX_CAP1 + 6'h1);
    c1 = q;
    rd(`FRTIC_IDX_CAP1 + 6'h2);
    check(q, c1);
    // shared channel as capture, fed by software pin writes
    wr(`FRTIC_IDX_SHARED, 32'h1234);
    rd(`FRTIC_IDX_SHARED);
    check(q, 32'h1234);
    wr(`FRTIC_IDX_CTRL, 32'h0C);
    wr(`FRTIC_IDX_SHARED, 32'h5678);
    rd(`FRTIC_IDX_SHARED);
    check(q, 32'h1234);
    wr(`FRTIC_IDX_PORT, 32'h0);
    wr(`FRTIC_IDX_EDGE, 32'hC0);
    wr(`FRTIC_IDX_FLAGS, 32'h3FF);
    wr(`FRTIC_IDX_PORT, 32'h08);
    repeat (8) @(posedge core_clk);
    check(port_a_oe_b[3], 1'b0);
    check(port_a_out[3], 1'b1);
    rd(`FRTIC_IDX_FLAGS);
    check(q[3], 1'b1);
    // compare 1 drives pin 7 a few counts ahead
    wr(`FRTIC_IDX_FLAGS, 32'h3FF);
    wr(`FRTIC_IDX_OC1, 32'h1010);
    rd(`FRTIC_IDX_COUNT);
    c0 = q;
    wr(`FRTIC_IDX_CMP1, (c0 + 32'd40) & 32'hFFFF);
    repeat (50) @(posedge core_clk);
    check(port_a_out[7], 1'b1);
    check(port_a_oe_b[7], 1'b0);
    rd(`FRTIC_IDX_FLAGS);
    check(q[4], 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
